// file: relay_shifter_map.svh
`ifndef RELAY_SHIFTER_MAP_SVH
`define RELAY_SHIFTER_MAP_SVH
// Crystal rate in Hz and its divider down to the bus clock
`define XTAL_FREQ_HZ 7159090
`define XTAL_DIV 4
// Core clock period in ns
`define MCLK_PERIOD_NS 50
// Bits per burst
`define BURST_BITS 8
// Core clocks per half bus-clock period (20 MHz / 1.78977 MHz / 2, rounded down)
`define BUS_HALF_CYCLES ((1000000000 / (`XTAL_FREQ_HZ / `XTAL_DIV)) / (2 * `MCLK_PERIOD_NS))
`define SHIFT_RESET 8'h00
`define COUNT_PRESET 8'hFF
`endif

// file: relay_shifter_pkg.sv
package relay_shifter_pkg;
  typedef struct packed {
    logic serial_clk;
    logic relay_serial_data;
    logic latch_pulse;
  } card_link_type;
  typedef struct packed {
    logic wr;
    logic [7:0] data;
  } cpu_write_type;
  typedef enum logic [1:0] {IDLE, FIRST, SHIFTING} burst_state_type;
endpackage : relay_shifter_pkg

// file: bus_clock_divider.sv
`timescale 1ns/1ps
`include "relay_shifter_map.svh"
// Derives the bus phase clock as a level toggling every half period
module bus_clock_divider #(
  parameter int HALF = `BUS_HALF_CYCLES
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Phase outputs
  output logic phase_o,
  output logic rise_o,
  output logic fall_o
);
  logic [7:0] cnt_r;
  logic phase_r;
  wire wrap = (cnt_r == 8'(HALF - 1));
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r <= 8'h00;
      phase_r <= 1'b0;
    end else begin
      cnt_r <= wrap ? 8'h00 : cnt_r + 8'h01;
      if (wrap) phase_r <= ~phase_r;
    end
  end
  assign phase_o = phase_r;
  assign rise_o = wrap & ~phase_r;
  assign fall_o = wrap & phase_r;
endmodule : bus_clock_divider

// file: relay_card_serial_shifter.sv
`timescale 1ns/1ps
`include "relay_shifter_map.svh"
module relay_card_serial_shifter
  import relay_shifter_pkg::*;
#(
  parameter int NUM_CARDS = 6
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Processor side
  input wire relay_shifter_pkg::cpu_write_type cpu_wr_i,
  input wire logic latch_i,
  input wire logic [NUM_CARDS-1:0] card_sel_i,
  output logic busy_o,
  output logic [7:0] card_id_byte_o,
  output logic card_id_valid_o,
  // Card link
  output relay_shifter_pkg::card_link_type link_o,
  output logic [NUM_CARDS-1:0] card_select_n_o,
  input wire logic card_id_serial_data_i
);
  import relay_shifter_pkg::*;

  logic phase, e_rise, e_fall;
  logic [7:0] shift_r;
  logic [7:0] count_r;
  logic [7:0] id_r;
  logic [2:0] id_sync_r;
  logic active_r, sclk_r, id_valid_r, latch_r;
  logic [NUM_CARDS-1:0] sel_r;
  burst_state_type state_r;

  // Core clocks per half bus-clock period, crystal divided by four
  localparam int HALF_CYCLES = `BUS_HALF_CYCLES;

  // Bus phase clock, the serial clock source
  bus_clock_divider #(
    .HALF(HALF_CYCLES)
  ) u_div (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .phase_o(phase),
    .rise_o(e_rise),
    .fall_o(e_fall)
  );

  wire counter_tail_output = count_r[7];
  // Writes during a burst are dropped, protecting data in flight
  wire take_wr = cpu_wr_i.wr & ~active_r;
  // A pulse is a fall that follows a driven high phase
  wire pulse_end = active_r & e_fall & sclk_r;
  // Burst ends after eight counted pulses
  wire last_pulse = pulse_end & (count_r == 8'h80);

  // Shared by the data and count registers, both move left by one
  function automatic logic [7:0] shl8(input logic [7:0] v);
    shl8 = {v[6:0], 1'b0};
  endfunction : shl8

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      shift_r <= `SHIFT_RESET;
      count_r <= 8'h00;
      active_r <= 1'b0;
      sclk_r <= 1'b0;
      state_r <= IDLE;
    end else if (take_wr) begin
      shift_r <= cpu_wr_i.data;
      count_r <= `COUNT_PRESET;
      active_r <= 1'b1;
      state_r <= IDLE;
    end else if (active_r) begin
      if (e_rise) begin
        sclk_r <= 1'b1;
        // The first high phase opens the first clock cycle
        if (state_r == IDLE) state_r <= FIRST;
      end
      // A fall before the first rise is no pulse: counting it would lose a bit
      if (pulse_end) begin
        sclk_r <= 1'b0;
        count_r <= shl8(count_r);
        // Inverted clock only acts once the first cycle has begun
        if (state_r != IDLE) shift_r <= shl8(shift_r);
        state_r <= SHIFTING;
        if (last_pulse) active_r <= 1'b0;
      end
    end
  end

  // Pulse count and high-phase length of a burst, read by the assertions only
  logic [3:0] pulse_cnt_r;
  logic [7:0] high_cnt_r;
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pulse_cnt_r <= 4'h0;
      high_cnt_r <= 8'h00;
    end else begin
      if (take_wr) pulse_cnt_r <= 4'h0;
      else if (active_r && e_rise) pulse_cnt_r <= pulse_cnt_r + 4'h1;
      high_cnt_r <= sclk_r ? high_cnt_r + 8'h01 : 8'h00;
    end
  end

  // ID bits sampled through three flops, taken on agreement
  logic id_bit_r;
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      id_sync_r <= 3'b000;
      id_bit_r <= 1'b0;
      id_r <= 8'h00;
      id_valid_r <= 1'b0;
      latch_r <= 1'b0;
      sel_r <= '0;
    end else begin
      id_sync_r <= {id_sync_r[1:0], card_id_serial_data_i};
      if (id_sync_r[2] == id_sync_r[1]) id_bit_r <= id_sync_r[1];
      if (active_r & e_rise) id_r <= {id_r[6:0], id_bit_r};
      id_valid_r <= last_pulse;
      latch_r <= latch_i & ~active_r;
      sel_r <= card_sel_i;
    end
  end

  // Clock and data are shared; selects are per card
  assign link_o.serial_clk = sclk_r;
  assign link_o.relay_serial_data = shift_r[7];
  assign link_o.latch_pulse = latch_r;
  assign card_select_n_o = ~sel_r;
  assign busy_o = active_r;
  assign card_id_byte_o = id_r;
  assign card_id_valid_o = id_valid_r;

  // Write and burst framing
  a_tail_on_write: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    take_wr |=> counter_tail_output && active_r)
    else $error("tail not set");

  a_load_data: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    take_wr |=> shift_r == $past(cpu_wr_i.data))
    else $error("load wrong");

  a_wr_ignored: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    cpu_wr_i.wr && active_r && !e_fall |=> $stable(shift_r))
    else $error("reload busy");

  // Clock gating and pulse count
  a_no_clk_idle: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !active_r && !take_wr |=> !$rose(sclk_r))
    else $error("clock when idle");

  a_burst_end: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    last_pulse |=> !active_r && !counter_tail_output)
    else $error("burst end");

  a_pulse_limit: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    pulse_cnt_r <= 4'h8)
    else $error("too many clock pulses");

  a_eight_pulses: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    last_pulse |-> pulse_cnt_r == 4'h8)
    else $error("burst pulse count");

  a_clk_gated: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    $rose(sclk_r) |-> active_r)
    else $error("ungated clock");

  // The serial clock keeps the bus phase shape, never a stretched high
  a_clk_follows_e: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    $rose(sclk_r) |-> phase)
    else $error("clock not bus phase");

  a_clk_width: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    sclk_r |-> high_cnt_r < 8'(HALF_CYCLES))
    else $error("clock high too long");

  // Data shifting
  a_first_hold: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    active_r && state_r == IDLE && e_fall && !take_wr |=> $stable(shift_r))
    else $error("shift in first cycle");

  // Identification byte, latch and selects
  a_valid_at_end: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    card_id_valid_o |-> !busy_o)
    else $error("id valid inside burst");

  a_latch_idle: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    link_o.latch_pulse |-> $past(!active_r))
    else $error("latch in burst");

  a_select_follow: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    card_select_n_o == ~$past(card_sel_i))
    else $error("select not following request");

  // Main scenarios; a write landing in a high phase exercises the first hold
  c_burst: cover property (@(posedge mclk_i) disable iff (!rst_n_i) last_pulse);
  c_wr_busy: cover property (@(posedge mclk_i) disable iff (!rst_n_i) cpu_wr_i.wr && active_r);
  c_latch: cover property (@(posedge mclk_i) disable iff (!rst_n_i) link_o.latch_pulse);
  c_late_start: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
    active_r && state_r == IDLE && e_fall);
  c_id_valid: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
    card_id_valid_o);
endmodule : relay_card_serial_shifter

// file: relay_card_chain.sv
`timescale 1ns/1ps
// Behavioural chain of latched relay drivers on one card
module relay_card_chain (
  // Link from the shifter, and the ID byte the card reports
  input wire logic clk_i,
  input wire logic data_i,
  input wire logic latch_i,
  input wire logic [7:0] id_byte_i,
  // Card state
  output logic [7:0] shift_o,
  output logic [7:0] latched_o,
  output logic id_o
);
  logic [2:0] id_cnt_r = 3'h0;
  always @(posedge clk_i) shift_o <= {shift_o[6:0], data_i};
  always @(posedge latch_i) latched_o <= shift_o;
  // Moves after each fall so the shifter sees it settled at the rise
  always @(negedge clk_i) id_cnt_r <= id_cnt_r + 3'h1;
  assign id_o = id_byte_i[3'h7 - id_cnt_r];
endmodule : relay_card_chain

// file: relay_card_serial_shifter_bench.sv
`timescale 1ns/1ps
module relay_card_serial_shifter_bench;
  import relay_shifter_pkg::*;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  cpu_write_type cpu_wr = '0;
  logic latch = 1'b0;
  logic [5:0] card_sel = 6'h00;
  logic busy, id_valid, id_bit;
  logic [7:0] id_byte, shifted, latched;
  logic [5:0] sel_n;
  card_link_type link;
  logic [7:0] id_src = 8'hA5;
  int mismatches = 0;
  int check_count = 0;
  int rises = 0;
  relay_card_serial_shifter i_relay_card_serial_shifter (.mclk_i(mclk), .rst_n_i(rst_n),
    .cpu_wr_i(cpu_wr), .latch_i(latch), .card_sel_i(card_sel), .busy_o(busy),
    .card_id_byte_o(id_byte), .card_id_valid_o(id_valid), .link_o(link),
    .card_select_n_o(sel_n), .card_id_serial_data_i(id_bit));
  relay_card_chain i_relay_card_chain (.clk_i(link.serial_clk), .data_i(link.relay_serial_data),
    .latch_i(link.latch_pulse), .id_byte_i(id_src), .shift_o(shifted), .latched_o(latched),
    .id_o(id_bit));
  initial begin
    forever #25 mclk = ~mclk;
  end
  always @(posedge link.serial_clk) rises++;
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : stop_test
  task automatic wait_idle;
    int n;
    for (n = 0; n < 300 && busy !== 1'b0; n++) @(negedge mclk);
    if (n == 300) begin
      mismatches++;
      stop_test();
    end
  endtask : wait_idle
  task automatic pulse_write(input logic [7:0] b);
    @(negedge mclk) cpu_wr = '{wr: 1'b1, data: b};
    @(negedge mclk) cpu_wr.wr = 1'b0;
  endtask : pulse_write
  task automatic send(input logic [7:0] b);
    int n;
    rises = 0;
    pulse_write(b);
    chk("busy", 8'h01, {7'h0, busy});
    for (n = 0; n < 300 && id_valid !== 1'b1; n++) @(negedge mclk);
    chk("id valid", 8'h01, {7'h0, id_valid});
    wait_idle();
    chk("clock count", 8'h08, rises[7:0]);
    chk("relay byte", b, shifted);
    chk("id byte", id_src, id_byte);
    $display("test send %h done", b);
  endtask : send
  task automatic refused_write;
    rises = 0;
    pulse_write(8'h96);
    repeat (10) @(negedge mclk);
    pulse_write(8'h00);
    wait_idle();
    chk("refused clocks", 8'h08, rises[7:0]);
    chk("refused byte", 8'h96, shifted);
    $display("test refused_write done");
  endtask : refused_write
  task automatic latch_and_select;
    latch = 1'b1;
    card_sel = 6'h05;
    repeat (3) @(negedge mclk);
    chk("latch pulse", 8'h01, {7'h0, link.latch_pulse});
    chk("latched", 8'h96, latched);
    chk("select", {2'h0, ~6'h05}, {2'h0, sel_n});
    latch = 1'b0;
    $display("test latch_and_select done");
  endtask : latch_and_select
  initial begin
    repeat (3) @(negedge mclk);
    rst_n = 1'b1;
    chk("select idle", 8'h3F, {2'h0, sel_n});
    send(8'h3C);
    send(8'hC3);
    refused_write();
    latch_and_select();
    stop_test();
  end
endmodule : relay_card_serial_shifter_bench
